// ===== rtl/flash_reset_device.sv
// Device end: power-on, pin and software reset sequencing of the flash.
// Assumes host signals are synchronous to clk_in; pin_a_level is the resolved wire.
`timescale 1ns/1ns
`default_nettype none
module flash_reset_device #(
    parameter int POWER_UP_CYCLES = flash_reset_pkg::POWER_UP_CYCLES,
    parameter int RECOVERY_CYCLES = flash_reset_pkg::RECOVERY_CYCLES,
    parameter int SOFT_RESET_CYCLES = flash_reset_pkg::SOFT_RESET_CYCLES
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    flash_reset_if.device   link,
    input  wire logic       quad_enable_in,
    input  wire logic       four_wire_mode_in,
    input  wire logic       function_b_in,
    input  wire logic       busy_writing_in,
    input  wire logic       read_data_quad_in,
    input  wire logic       por_fault_in,
    output logic            ready_out,
    output logic            in_reset_out,
    output logic            outputs_hiz_out,
    output logic            abort_out,
    output logic            reissue_needed_out,
    output logic            regs_reset_out
);
    typedef enum {S_POWER_UP, S_READY, S_HW_RESET, S_SOFT_RESET} state_t;
    localparam logic [flash_reset_pkg::CNT_W-1:0] ONE = 16'h0001;

    state_t                           state, next_state;
    logic [flash_reset_pkg::CNT_W-1:0] cnt, next_cnt;
    logic [flash_reset_pkg::CNT_W-1:0] low_cnt, next_low_cnt;
    logic [flash_reset_pkg::CNT_W-1:0] desel_cnt, next_desel_cnt;
    logic                             rst_en_seen, next_rst_en_seen;
    logic                             drive_a, next_drive_a;
    logic                             reissue, next_reissue;
    logic                             por_ok, next_por_ok;
    logic                             regs_rst, next_regs_rst;
    logic                             quad_mode;
    logic                             pin_a_reset_ok;
    logic                             reset_low;
    logic                             hw_trigger;

    assign quad_mode = quad_enable_in && four_wire_mode_in;
    // Deselect filter lets the drivers release IO3 before it counts as reset
    assign pin_a_reset_ok = function_b_in
        && (!quad_mode || (link.cs_n &&
            desel_cnt >= flash_reset_pkg::CNT_W'(flash_reset_pkg::DESELECT_CYCLES)));
    // Undriven shared pin reads high through the pull-up, modelled on the wire
    assign reset_low = !link.reset_n || (pin_a_reset_ok && !link.pin_a_level);
    assign hw_trigger = low_cnt >= flash_reset_pkg::CNT_W'(flash_reset_pkg::PULSE_CYCLES);

    always_comb begin
        next_state       = state;
        next_cnt         = cnt + ONE;
        next_low_cnt     = reset_low ? low_cnt + ONE : '0;
        next_desel_cnt   = !link.cs_n ? '0 :
                           (desel_cnt == '1 ? desel_cnt : desel_cnt + ONE);
        next_rst_en_seen = rst_en_seen;
        next_drive_a     = drive_a;
        next_reissue     = reissue;
        next_por_ok      = por_ok;
        next_regs_rst    = 1'b0;
        if (!link.cs_n && read_data_quad_in)
            next_drive_a = 1'b1;
        else if (!link.cs_n ||
                 desel_cnt >= flash_reset_pkg::CNT_W'(flash_reset_pkg::DESELECT_CYCLES))
            next_drive_a = 1'b0;
        case (state)
            S_POWER_UP: begin
                next_low_cnt = '0;
                if (cnt >= flash_reset_pkg::CNT_W'(POWER_UP_CYCLES - 1)) begin
                    next_por_ok = !por_fault_in;
                    next_cnt    = '0;
                    next_state  = S_READY;
                end
            end
            S_READY: begin
                if (hw_trigger) begin
                    next_cnt      = '0;
                    next_reissue  = busy_writing_in;
                    next_regs_rst = 1'b1;
                    next_drive_a  = 1'b0;
                    next_state    = por_ok ? S_HW_RESET : S_POWER_UP;
                end else if (link.cmd_valid) begin
                    next_reissue = 1'b0;
                    if (rst_en_seen && link.cmd == flash_reset_pkg::RESET_CMD) begin
                        next_cnt         = '0;
                        next_regs_rst    = 1'b1;
                        next_rst_en_seen = 1'b0;
                        next_state       = S_SOFT_RESET;
                    end else
                        next_rst_en_seen = (link.cmd == flash_reset_pkg::RESET_ENABLE_CMD);
                end
            end
            S_HW_RESET: begin
                next_rst_en_seen = 1'b0;
                if (cnt >= flash_reset_pkg::CNT_W'(RECOVERY_CYCLES - 1)) begin
                    next_cnt   = '0;
                    next_state = S_READY;
                end
            end
            S_SOFT_RESET: begin
                next_low_cnt = '0;
                if (cnt >= flash_reset_pkg::CNT_W'(SOFT_RESET_CYCLES - 1)) begin
                    next_cnt   = '0;
                    next_state = S_READY;
                end
            end
            default: next_state = S_POWER_UP;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state       <= S_POWER_UP;
            cnt         <= '0;
            low_cnt     <= '0;
            desel_cnt   <= '0;
            rst_en_seen <= 1'b0;
            drive_a     <= 1'b0;
            reissue     <= 1'b0;
            por_ok      <= 1'b0;
            regs_rst    <= 1'b0;
        end else begin
            state       <= next_state;
            cnt         <= next_cnt;
            low_cnt     <= next_low_cnt;
            desel_cnt   <= next_desel_cnt;
            rst_en_seen <= next_rst_en_seen;
            drive_a     <= next_drive_a;
            reissue     <= next_reissue;
            por_ok      <= next_por_ok;
            regs_rst    <= next_regs_rst;
        end
    end

    assign link.pin_a_dev_out = 1'b1;
    assign link.pin_a_dev_oe  = drive_a && state == S_READY;
    assign ready_out          = state == S_READY;
    assign in_reset_out       = state != S_READY;
    assign outputs_hiz_out    = state == S_HW_RESET || state == S_POWER_UP;
    assign abort_out          = regs_rst;
    assign reissue_needed_out = reissue;
    assign regs_reset_out     = regs_rst;
endmodule // flash_reset_device
`default_nettype wire

// ===== rtl/flash_reset_host.sv
// Host end: sequences chip select, reset pin and shared pin around flash resets.
// Assumes the device end shares clk_in and the pin wire is resolved outside.
`timescale 1ns/1ns
`default_nettype none
module flash_reset_host #(
    parameter int POWER_UP_CYCLES = flash_reset_pkg::POWER_UP_CYCLES,
    parameter int RECOVERY_CYCLES = flash_reset_pkg::RECOVERY_CYCLES
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    flash_reset_if.host     link,
    input  wire logic       hw_reset_req_in,
    input  wire logic       use_pin_a_in,
    input  wire logic       cmd_req_in,
    input  wire logic [7:0] cmd_in,
    input  wire logic       write_quad_in,
    output logic            busy_out,
    output logic            cmd_ack_out
);
    typedef enum {H_POWER_UP, H_SETUP, H_IDLE, H_CMD, H_PULSE, H_HOLD} hstate_t;
    localparam logic [flash_reset_pkg::CNT_W-1:0] ONE = 16'h0001;
    localparam int HOLD_WAIT = (RECOVERY_CYCLES > flash_reset_pkg::PULSE_CYCLES
                                + flash_reset_pkg::HOLD_CYCLES) ?
                               RECOVERY_CYCLES - flash_reset_pkg::PULSE_CYCLES
                               : flash_reset_pkg::HOLD_CYCLES;

    hstate_t                          state, next_state;
    logic [flash_reset_pkg::CNT_W-1:0] cnt, next_cnt;
    logic                             hi_a, next_hi_a;
    logic [7:0]                       cmd_q, next_cmd_q;

    always_comb begin
        next_state = state;
        next_cnt   = cnt + ONE;
        next_hi_a  = 1'b0;
        next_cmd_q = cmd_q;
        case (state)
            H_POWER_UP:
                if (cnt >= flash_reset_pkg::CNT_W'(POWER_UP_CYCLES - 1)) begin
                    next_cnt = '0;
                    next_state = H_SETUP;
                end
            H_SETUP:
                if (cnt >= flash_reset_pkg::CNT_W'(flash_reset_pkg::SETUP_CYCLES)) begin
                    next_cnt = '0;
                    next_state = H_IDLE;
                end
            H_IDLE: begin
                next_cnt = '0;
                if (hw_reset_req_in)
                    next_state = H_PULSE;
                else if (cmd_req_in) begin
                    next_cmd_q = cmd_in;
                    next_state = H_CMD;
                end
            end
            H_CMD: begin
                next_hi_a  = write_quad_in;
                next_state = H_IDLE;
            end
            H_PULSE:
                if (cnt >= flash_reset_pkg::CNT_W'(flash_reset_pkg::PULSE_CYCLES)) begin
                    next_cnt = '0;
                    next_state = H_HOLD;
                end
            H_HOLD:
                if (cnt >= flash_reset_pkg::CNT_W'(HOLD_WAIT)) begin
                    next_cnt = '0;
                    next_state = H_SETUP;
                end
            default: next_state = H_POWER_UP;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= H_POWER_UP;
            cnt   <= '0;
            hi_a  <= 1'b0;
            cmd_q <= 8'h00;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            hi_a  <= next_hi_a;
            cmd_q <= next_cmd_q;
        end
    end

    assign link.cs_n           = state != H_CMD;
    assign link.cmd_valid      = state == H_CMD;
    assign link.cmd            = cmd_q;
    assign link.reset_n        = !(state == H_PULSE && !use_pin_a_in);
    assign link.pin_a_host_out = state != H_PULSE;
    assign link.pin_a_host_oe  = hi_a || (state == H_PULSE && use_pin_a_in);
    assign busy_out            = state != H_IDLE;
    assign cmd_ack_out         = state == H_CMD;
endmodule // flash_reset_host
`default_nettype wire

// ===== rtl/flash_reset_if.sv
// Link between the host controller and the flash reset logic.
// The testbench resolves pin_a_level from the two enables plus a pull-up.
`timescale 1ns/1ns
`default_nettype none
interface flash_reset_if;
    logic       cs_n;
    logic       reset_n;
    logic       cmd_valid;
    logic [7:0] cmd;
    logic       pin_a_host_out;
    logic       pin_a_host_oe;
    logic       pin_a_dev_out;
    logic       pin_a_dev_oe;
    logic       pin_a_level;
    modport device (input cs_n, reset_n, cmd_valid, cmd, pin_a_level,
                    output pin_a_dev_out, pin_a_dev_oe);
    modport host (output cs_n, reset_n, cmd_valid, cmd, pin_a_host_out, pin_a_host_oe,
                  input pin_a_level);
endinterface
`default_nettype wire

// ===== rtl/flash_reset_pkg.sv
// Constants shared by the flash reset device end and the host end.
// Assumes a single 10 MHz system clock on both ends.
package flash_reset_pkg;
    localparam int CLK_PERIOD_NS         = 100;
    localparam int POWER_UP_DELAY_US     = 300;
    localparam int RESET_HOLD_TIME_NS    = 150;
    localparam int RESET_SETUP_TIME_NS   = 50;
    localparam int RESET_PULSE_WIDTH_NS  = 200;
    localparam int RESET_RECOVERY_US     = 100;
    localparam int DESELECT_TIME_NS      = 50;
    localparam int SOFT_RESET_TIME_US    = 30;
    // Least times round up
    localparam int HOLD_CYCLES     = (RESET_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYCLES    = (RESET_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYCLES    = (RESET_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DESELECT_CYCLES = (DESELECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWER_UP_CYCLES = (POWER_UP_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVERY_CYCLES = (RESET_RECOVERY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SOFT_RESET_CYCLES = (SOFT_RESET_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    localparam logic [7:0] RESET_ENABLE_CMD = 8'h66;
    localparam logic [7:0] RESET_CMD        = 8'h99;
    localparam int QUAD_ENABLE_BIT   = 1;
    localparam int FOUR_WIRE_BIT     = 3;
    localparam int FUNCTION_B_BIT    = 7;
endpackage

// ===== sim/flash_reset_asserts.sv
// Checker for the link between the flash host end and device end.
// Assumes one clock; inputs are the link signals, wired by the testbench.
`timescale 1ns/1ns
`default_nettype none
module flash_reset_asserts #(
    parameter int POWER_UP_CYCLES = flash_reset_pkg::POWER_UP_CYCLES,
    parameter int RECOVERY_CYCLES = flash_reset_pkg::RECOVERY_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cs_n_in,
    input wire logic reset_n_in,
    input wire logic cmd_valid_in,
    input wire logic pin_a_host_out_in,
    input wire logic pin_a_host_oe_in,
    input wire logic pin_a_dev_out_in,
    input wire logic pin_a_dev_oe_in
);
    localparam int LATE = flash_reset_pkg::PULSE_CYCLES + 1;
    int   up_cnt;
    int   low_cnt;
    logic host_rst;
    assign host_rst = !reset_n_in || (pin_a_host_oe_in && !pin_a_host_out_in && cs_n_in);
    // Cycles since release and since the last driven reset low
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            up_cnt  <= 0;
            low_cnt <= RECOVERY_CYCLES;
        end else begin
            up_cnt  <= (up_cnt < POWER_UP_CYCLES) ? up_cnt + 1 : up_cnt;
            low_cnt <= host_rst ? 0 : ((low_cnt < RECOVERY_CYCLES) ? low_cnt + 1 : low_cnt);
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    chk_powerup_desel: assert property (up_cnt < POWER_UP_CYCLES |-> cs_n_in)
        else $error("chip select low during power-up");
    // The reset pulse lasts LATE cycles, so the count restarts that much late
    chk_recovery_wait: assert property (!cs_n_in |-> low_cnt >= RECOVERY_CYCLES - LATE)
        else $error("chip select low inside recovery time");
    chk_reset_width: assert property ($fell(reset_n_in) |=> !reset_n_in [*2])
        else $error("reset pulse too short");
    chk_hold_time: assert property ($rose(reset_n_in) |-> cs_n_in [*2])
        else $error("chip select low inside hold time");
    chk_cmd_select: assert property (cmd_valid_in |-> !cs_n_in)
        else $error("command without chip select");
    chk_cs_pulse: assert property ($fell(cs_n_in) |=> $rose(cs_n_in))
        else $error("chip select low longer than one cycle");
    chk_no_contend: assert property (!(pin_a_host_oe_in && pin_a_dev_oe_in))
        else $error("both ends drive the shared pin");
    chk_dev_pin_high: assert property (pin_a_dev_oe_in |-> cs_n_in && pin_a_dev_out_in)
        else $error("device drives shared pin low or while selected");
endmodule // flash_reset_asserts
`default_nettype wire

// ===== sim/tb.sv
// Testbench joining the flash host end and device end through the link.
// Assumes shortened counts; the shared pin is resolved here with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int PU = 20;
    localparam int RC = 30;
    logic clk_in, rst_n_in, qe, fw, fb, bw, rq, pf, hreq, upa, creq, wq;
    logic [7:0] cin;
    logic ready, inr, hiz, abrt, reis, regs, busy, ack, abrt_seen, regs_seen;
    int n_errors, n_checks;
    logic [7:0] q[$];
    flash_reset_if link();
    assign link.pin_a_level = link.pin_a_host_oe ? link.pin_a_host_out :
                              (link.pin_a_dev_oe ? link.pin_a_dev_out : 1'b1);
    flash_reset_device #(.POWER_UP_CYCLES(PU), .RECOVERY_CYCLES(RC), .SOFT_RESET_CYCLES(10))
    flash_reset_device_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link),
        .quad_enable_in(qe), .four_wire_mode_in(fw), .function_b_in(fb),
        .busy_writing_in(bw), .read_data_quad_in(rq), .por_fault_in(pf), .ready_out(ready),
        .in_reset_out(inr), .outputs_hiz_out(hiz), .abort_out(abrt),
        .reissue_needed_out(reis), .regs_reset_out(regs));
    flash_reset_host #(.POWER_UP_CYCLES(PU), .RECOVERY_CYCLES(RC))
    flash_reset_host_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link),
        .hw_reset_req_in(hreq), .use_pin_a_in(upa), .cmd_req_in(creq), .cmd_in(cin),
        .write_quad_in(wq), .busy_out(busy), .cmd_ack_out(ack));
    flash_reset_asserts #(.POWER_UP_CYCLES(PU), .RECOVERY_CYCLES(RC))
    flash_reset_asserts_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(link.cs_n),
        .reset_n_in(link.reset_n), .cmd_valid_in(link.cmd_valid),
        .pin_a_host_out_in(link.pin_a_host_out), .pin_a_host_oe_in(link.pin_a_host_oe),
        .pin_a_dev_out_in(link.pin_a_dev_out), .pin_a_dev_oe_in(link.pin_a_dev_oe));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Bounded wait: 0 ready, 1 in reset, 2 host idle; n counts edges
    task automatic wait_on(input int w, input int lim, output int n);
        n = 0;
        do begin
            @(posedge clk_in);
            #1;
            n++;
            if (n > lim) begin
                chk(0, 1);
                summarize();
            end
        end while (!(w == 0 ? ready === 1'b1 : (w == 1 ? inr === 1'b1 : busy === 1'b0)));
    endtask
    task automatic send(input logic [7:0] c);
        int n;
        logic [1:0] r;
        wait_on(2, 60, n);
        r = 2'($urandom);
        q.push_back(c);
        @(posedge clk_in);
        creq <= 1'b1;
        cin  <= c;
        // A command reads or writes, never both, so one end at most drives the pin
        wq   <= r[1] && !r[0];
        rq   <= r[0];
        @(posedge clk_in);
        creq <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask
    // Hardware reset by pin or shared pin during a write; lo is the least recovery
    task automatic hw(input logic pin, input logic exp, input int lo);
        int n;
        wait_on(2, 60, n);
        abrt_seen = 1'b0;
        regs_seen = 1'b0;
        @(posedge clk_in);
        upa  <= pin;
        bw   <= 1'b1;
        hreq <= 1'b1;
        n = 0;
        while (inr !== 1'b1 && n < 12) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        chk(inr, exp);
        @(posedge clk_in);
        hreq <= 1'b0;
        bw   <= 1'b0;
        if (exp) begin
            #1;
            chk(hiz, 1);
            chk(reis, 1);
            wait_on(0, lo + 40, n);
            chk(n >= lo - 2, 1);
            chk({abrt_seen, regs_seen}, 2'b11);
        end else
            chk({abrt_seen, regs_seen}, 2'b00);
    endtask
    always @(posedge clk_in) begin
        if (abrt === 1'b1) abrt_seen <= 1'b1;
        if (regs === 1'b1) regs_seen <= 1'b1;
        if (link.cmd_valid === 1'b1) begin
            if (q.size() == 0) chk(0, 1);
            else chk({24'h0, link.cmd}, {24'h0, q.pop_front()});
        end
    end
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    initial begin
        int n;
        logic [7:0] c;
        {rst_n_in, bw, rq, pf, hreq, upa, creq, wq, cin} = '0;
        {qe, fw, fb, abrt_seen, regs_seen, n_errors, n_checks} = {3'b111, 2'b00, 64'h0};
        void'($urandom(32'hFD9B165E));
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        #1;
        chk({ready, hiz}, 2'b01);
        wait_on(0, PU + 20, n);
        chk(n >= PU, 1);
        repeat (6) begin
            c = 8'($urandom);
            send((c == 8'h66 || c == 8'h99) ? 8'h05 : c);
        end
        send(8'h66);
        send(8'h05);
        send(8'h99);
        #1;
        chk(inr, 0);
        send(8'h66);
        send(8'h99);
        #1;
        chk(inr, 1);
        wait_on(1, 4, n);
        wait_on(0, 40, n);
        hw(1'b0, 1'b1, RC);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in);
            {qe, fw} <= 2'(i);
            hw(1'b1, 1'b1, RC);
        end
        @(posedge clk_in);
        fb <= 1'b0;
        hw(1'b1, 1'b0, RC);
        @(posedge clk_in);
        fb       <= 1'b1;
        rst_n_in <= 1'b0;
        pf       <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        #1;
        chk({ready, hiz, reis, busy}, 4'b0101);
        wait_on(0, PU + 20, n);
        hw(1'b0, 1'b1, PU);
        summarize();
    end
endmodule // tb
`default_nettype wire
